/* File: hall_pkg.sv */
`default_nettype none
package hall_pkg;

    // Register map
    localparam logic [7:0] ADDR_GLOBAL_EVENTS      = 8'h11;
    localparam logic [7:0] ADDR_FLAGS              = 8'h16;
    localparam logic [7:0] ADDR_AMP_LOW            = 8'h17;
    localparam logic [7:0] ADDR_AMP_HIGH           = 8'h18;
    localparam logic [7:0] ADDR_CHARGE_TUNING      = 8'h90;
    localparam logic [7:0] ADDR_TUNING_BASE_TARGET = 8'h91;
    localparam logic [7:0] ADDR_SWITCH_CFG         = 8'hA0;
    localparam logic [7:0] ADDR_PROX_THR           = 8'hA1;
    localparam logic [7:0] ADDR_TOUCH_THR          = 8'hA2;

    // Field positions
    localparam int EVT_HALL_BIT    = 2;
    localparam int FLAG_POL_BIT    = 0;
    localparam int FLAG_PROX_BIT   = 1;
    localparam int FLAG_TOUCH_BIT  = 2;
    localparam int CHARGE_DIV_LSB  = 0;
    localparam int CHARGE_DIV_W    = 4;
    localparam int TUNE_MODE_LSB   = 4;
    localparam int TUNE_MODE_W     = 2;
    localparam int TUNE_BASE_LSB   = 0;
    localparam int TUNE_TARGET_LSB = 4;
    localparam int TUNE_FIELD_W    = 4;
    localparam int SW_EN_BIT       = 0;
    localparam int SW_LIN_BIT      = 1;

    // Reset values
    localparam logic [7:0] RST_CHARGE_TUNING      = 8'h30;
    localparam logic [7:0] RST_TUNING_BASE_TARGET = 8'h82;
    localparam logic [7:0] RST_SWITCH_CFG         = 8'h01;
    localparam logic [7:0] RST_PROX_THR           = 8'h10;
    localparam logic [7:0] RST_TOUCH_THR          = 8'h40;

    // Amplitude and threshold scaling
    localparam int AMP_W      = 16;
    localparam int THR_SHIFT  = 4;
    typedef logic [AMP_W-1:0] amp_t;

    // Conversion pacing
    localparam int CLK_PERIOD_NS     = 8;
    localparam int CONV_BASE_NS      = 1000;
    localparam int CONV_BASE_CYCLES  = (CONV_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_W        = 12;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DIVIDE = 2'b01,
        ST_UPDATE = 2'b10
    } proc_state_t;

endpackage
`default_nettype wire

/* File: inverse_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module inverse_divider #(
    parameter int NW = 32,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // Request
    input  wire logic          start,
    input  wire logic [NW-1:0] num,
    input  wire logic [DW-1:0] den,
    // Result
    output logic               busy,
    output logic               done,
    output logic [NW-1:0]      quo
);
    localparam int CW = $clog2(NW + 1);

    initial begin
        if (NW < 2 || DW < 2 || DW > NW) begin
            $error("inverse_divider: unsupported widths");
        end
    end

    logic [CW-1:0] cnt_q, cnt_d;
    logic [DW:0]   rem_q, rem_d;
    logic [DW-1:0] den_q, den_d;
    logic [NW-1:0] quo_q, quo_d;
    logic          busy_q, busy_d;
    logic          done_q, done_d;
    logic [DW:0]   rem_sh;

    // Restoring division, one quotient bit per cycle; zero divisor gives all ones
    always_comb begin
        cnt_d  = cnt_q;
        rem_d  = rem_q;
        den_d  = den_q;
        quo_d  = quo_q;
        busy_d = busy_q;
        done_d = 1'b0;
        rem_sh = {rem_q[DW-1:0], quo_q[NW-1]};
        if (start && !busy_q) begin
            cnt_d  = CW'(NW);
            rem_d  = '0;
            den_d  = den;
            quo_d  = num;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (rem_sh >= {1'b0, den_q}) begin
                rem_d = rem_sh - {1'b0, den_q};
                quo_d = {quo_q[NW-2:0], 1'b1};
            end else begin
                rem_d = rem_sh;
                quo_d = {quo_q[NW-2:0], 1'b0};
            end
            cnt_d = cnt_q - CW'(1);
            if (cnt_q == CW'(1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            rem_q  <= '0;
            den_q  <= '0;
            quo_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= cnt_d;
            rem_q  <= rem_d;
            den_q  <= den_d;
            quo_q  <= quo_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign quo  = quo_q;

endmodule
`default_nettype wire

/* File: hall_effect_sensing_ui.sv */
`timescale 1ns/1ps
`default_nettype none
module hall_effect_sensing_ui #(
    parameter int          CH_W       = 16,
    parameter logic [31:0] LIN_NUMER  = 32'h0100_0000
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 ce,
    // Magnetic channel results from the sensing engine
    input  wire logic [CH_W-1:0]      ch4_count,
    input  wire logic [CH_W-1:0]      ch5_count,
    input  wire logic                 meas_valid,
    // Register port behind the serial slave
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Front end control
    output logic                      conv_start,
    output logic [hall_pkg::CHARGE_DIV_W-1:0] charge_div,
    output logic [hall_pkg::TUNE_MODE_W-1:0]  automatic_tuning_mode,
    output logic [hall_pkg::TUNE_FIELD_W-1:0] automatic_tuning_base,
    output logic [hall_pkg::TUNE_FIELD_W-1:0] automatic_tuning_target,
    // Detection outputs
    output logic                      magnetic_prox_out,
    output logic                      magnetic_touch_out,
    output logic                      magnetic_polarity,
    output logic                      magnetic_event
);
    initial begin
        if (CH_W < 2 || CH_W > hall_pkg::AMP_W) begin
            $error("hall_effect_sensing_ui: CH_W out of range");
        end
    end

    localparam int CW = hall_pkg::CONV_CNT_W;

    function automatic logic above_thr(input hall_pkg::amp_t amp, input logic [7:0] thr);
        above_thr = amp > (hall_pkg::amp_t'(thr) << hall_pkg::THR_SHIFT);
    endfunction

    logic [7:0]            cfg0_q, cfg0_d, cfg1_q, cfg1_d, swcfg_q, swcfg_d;
    logic [7:0]            pthr_q, pthr_d, tthr_q, tthr_d;
    logic [7:0]            rdata_q, rdata_d, amp_hi_sh_q, amp_hi_sh_d;
    logic [CW-1:0]         conv_cnt_q, conv_cnt_d, period_m1;
    logic                  conv_q, conv_d;
    hall_pkg::proc_state_t st_q, st_d;
    hall_pkg::amp_t        raw_q, raw_d, amp_q, amp_d, quo_sat;
    logic                  lin_q, lin_d, pol_q, pol_d;
    logic                  prox_q, prox_d, touch_q, touch_d, evt_q, evt_d;
    logic [CH_W:0]         diff;
    logic [CH_W-1:0]       mag;
    logic                  div_start, div_done, div_busy;
    logic [31:0]           div_quo;
    logic                  sw_en;

    // Positive channel minus negative channel removes common mode
    assign diff  = {1'b0, ch4_count} - {1'b0, ch5_count};
    assign mag   = diff[CH_W] ? CH_W'(-diff) : diff[CH_W-1:0];
    assign sw_en = swcfg_q[hall_pkg::SW_EN_BIT];
    assign period_m1 = CW'((32'(cfg0_q[hall_pkg::CHARGE_DIV_LSB +: hall_pkg::CHARGE_DIV_W]) + 32'd1)
                           * hall_pkg::CONV_BASE_CYCLES - 1);
    assign quo_sat = (div_quo[31:hall_pkg::AMP_W] != '0) ? '1 : div_quo[hall_pkg::AMP_W-1:0];

    inverse_divider #(
        .NW (32),
        .DW (hall_pkg::AMP_W)
    ) u_inv (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .start (div_start),
        .num   (LIN_NUMER),
        .den   (hall_pkg::amp_t'(mag)),
        .busy  (div_busy),
        .done  (div_done),
        .quo   (div_quo)
    );

    always_comb begin
        cfg0_d      = cfg0_q;
        cfg1_d      = cfg1_q;
        swcfg_d     = swcfg_q;
        pthr_d      = pthr_q;
        tthr_d      = tthr_q;
        rdata_d     = rdata_q;
        amp_hi_sh_d = amp_hi_sh_q;
        st_d        = st_q;
        raw_d       = raw_q;
        amp_d       = amp_q;
        lin_d       = lin_q;
        pol_d       = pol_q;
        div_start   = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                hall_pkg::ADDR_CHARGE_TUNING:      cfg0_d  = reg_wdata;
                hall_pkg::ADDR_TUNING_BASE_TARGET: cfg1_d  = reg_wdata;
                hall_pkg::ADDR_SWITCH_CFG:         swcfg_d = reg_wdata;
                hall_pkg::ADDR_PROX_THR:           pthr_d  = reg_wdata;
                hall_pkg::ADDR_TOUCH_THR:          tthr_d  = reg_wdata;
                default:                           cfg0_d  = cfg0_q;
            endcase
        end
        // Low byte read freezes the high byte so a two-read pair is coherent
        if (reg_rd) begin
            case (reg_addr)
                hall_pkg::ADDR_GLOBAL_EVENTS:      rdata_d = 8'(evt_q) << hall_pkg::EVT_HALL_BIT;
                hall_pkg::ADDR_FLAGS:              rdata_d = (8'(touch_q) << hall_pkg::FLAG_TOUCH_BIT)
                                                           | (8'(prox_q) << hall_pkg::FLAG_PROX_BIT)
                                                           | (8'(pol_q) << hall_pkg::FLAG_POL_BIT);
                hall_pkg::ADDR_AMP_LOW: begin
                    rdata_d     = amp_q[7:0];
                    amp_hi_sh_d = amp_q[15:8];
                end
                hall_pkg::ADDR_AMP_HIGH:           rdata_d = amp_hi_sh_q;
                hall_pkg::ADDR_CHARGE_TUNING:      rdata_d = cfg0_q;
                hall_pkg::ADDR_TUNING_BASE_TARGET: rdata_d = cfg1_q;
                hall_pkg::ADDR_SWITCH_CFG:         rdata_d = swcfg_q;
                hall_pkg::ADDR_PROX_THR:           rdata_d = pthr_q;
                hall_pkg::ADDR_TOUCH_THR:          rdata_d = tthr_q;
                default:                           rdata_d = 8'h00;
            endcase
        end
        // Only the two dedicated channels reach this path; samples during a divide are dropped
        case (st_q)
            hall_pkg::ST_IDLE: begin
                if (meas_valid && sw_en) begin
                    raw_d = hall_pkg::amp_t'(mag);
                    pol_d = diff[CH_W];
                    lin_d = swcfg_q[hall_pkg::SW_LIN_BIT];
                    if (swcfg_q[hall_pkg::SW_LIN_BIT]) begin
                        div_start = 1'b1;
                        st_d      = hall_pkg::ST_DIVIDE;
                    end else begin
                        st_d = hall_pkg::ST_UPDATE;
                    end
                end
            end
            hall_pkg::ST_DIVIDE: begin
                if (div_done) begin
                    st_d = hall_pkg::ST_UPDATE;
                end
            end
            hall_pkg::ST_UPDATE: begin
                amp_d = lin_q ? quo_sat : raw_q;
                st_d  = hall_pkg::ST_IDLE;
            end
            default: st_d = hall_pkg::ST_IDLE;
        endcase
    end

    // Flags follow the amplitude continuously; event toggles on each new detection
    always_comb begin
        prox_d  = sw_en && above_thr(amp_q, pthr_q);
        touch_d = sw_en && above_thr(amp_q, tthr_q);
        evt_d   = evt_q ^ ((prox_d && !prox_q) || (touch_d && !touch_q));
    end

    // Conversion pacing from the charge divider
    always_comb begin
        if (conv_cnt_q == '0) begin
            conv_cnt_d = period_m1;
            conv_d     = 1'b1;
        end else begin
            conv_cnt_d = conv_cnt_q - CW'(1);
            conv_d     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg0_q      <= hall_pkg::RST_CHARGE_TUNING;
            cfg1_q      <= hall_pkg::RST_TUNING_BASE_TARGET;
            swcfg_q     <= hall_pkg::RST_SWITCH_CFG;
            pthr_q      <= hall_pkg::RST_PROX_THR;
            tthr_q      <= hall_pkg::RST_TOUCH_THR;
            rdata_q     <= 8'h00;
            amp_hi_sh_q <= 8'h00;
            st_q        <= hall_pkg::ST_IDLE;
            raw_q       <= '0;
            amp_q       <= '0;
            lin_q       <= 1'b0;
            pol_q       <= 1'b0;
            prox_q      <= 1'b0;
            touch_q     <= 1'b0;
            evt_q       <= 1'b0;
            conv_cnt_q  <= '0;
            conv_q      <= 1'b0;
        end else if (ce) begin
            cfg0_q      <= cfg0_d;
            cfg1_q      <= cfg1_d;
            swcfg_q     <= swcfg_d;
            pthr_q      <= pthr_d;
            tthr_q      <= tthr_d;
            rdata_q     <= rdata_d;
            amp_hi_sh_q <= amp_hi_sh_d;
            st_q        <= st_d;
            raw_q       <= raw_d;
            amp_q       <= amp_d;
            lin_q       <= lin_d;
            pol_q       <= pol_d;
            prox_q      <= prox_d;
            touch_q     <= touch_d;
            evt_q       <= evt_d;
            conv_cnt_q  <= conv_cnt_d;
            conv_q      <= conv_d;
        end
    end

    assign reg_rdata               = rdata_q;
    assign conv_start              = conv_q && ce;
    assign charge_div              = cfg0_q[hall_pkg::CHARGE_DIV_LSB +: hall_pkg::CHARGE_DIV_W];
    assign automatic_tuning_mode   = cfg0_q[hall_pkg::TUNE_MODE_LSB +: hall_pkg::TUNE_MODE_W];
    assign automatic_tuning_base   = cfg1_q[hall_pkg::TUNE_BASE_LSB +: hall_pkg::TUNE_FIELD_W];
    assign automatic_tuning_target = cfg1_q[hall_pkg::TUNE_TARGET_LSB +: hall_pkg::TUNE_FIELD_W];
    assign magnetic_prox_out       = prox_q;
    assign magnetic_touch_out      = touch_q;
    assign magnetic_polarity       = pol_q;
    assign magnetic_event          = evt_q;

    // Helper: spacing between divider reloads
    logic [CW-1:0] gap_q, per_q;
    logic          seen_q, wrote_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q   <= '0;
            per_q   <= '0;
            seen_q  <= 1'b0;
            wrote_q <= 1'b0;
        end else if (ce) begin
            if (conv_cnt_q == '0) begin
                gap_q   <= CW'(1);
                per_q   <= period_m1 + CW'(1);
                seen_q  <= 1'b1;
                wrote_q <= reg_wr && reg_addr == hall_pkg::ADDR_CHARGE_TUNING;
            end else begin
                gap_q   <= gap_q + CW'(1);
                wrote_q <= wrote_q || (reg_wr && reg_addr == hall_pkg::ADDR_CHARGE_TUNING);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    drop_busy_a: assert property (ce && meas_valid && st_q != hall_pkg::ST_IDLE |=> $stable(raw_q))
        else $error("sample taken while busy");
    diff_capture_a: assert property (ce && st_q == hall_pkg::ST_IDLE && meas_valid && sw_en
        |=> raw_q == hall_pkg::amp_t'($past(mag)) && pol_q == $past(ch5_count > ch4_count))
        else $error("differential capture wrong");
    raw_report_a: assert property (ce && st_q == hall_pkg::ST_UPDATE && !lin_q |=> amp_q == $past(raw_q))
        else $error("raw amplitude not reported");
    lin_report_a: assert property (ce && st_q == hall_pkg::ST_UPDATE && lin_q |=> amp_q == $past(quo_sat))
        else $error("linearized amplitude not reported");
    div_launch_a: assert property (ce && div_start |=> div_busy)
        else $error("inverse divider not started");
    event_toggle_a: assert property ($changed(evt_q) |-> $rose(prox_q) || $rose(touch_q))
        else $error("event toggled without detection");
    flags_read_a: assert property (ce && reg_rd && reg_addr == hall_pkg::ADDR_FLAGS
        |=> reg_rdata == {5'h00, $past(touch_q), $past(prox_q), $past(pol_q)})
        else $error("flags read wrong");
    amp_pair_a: assert property (ce && reg_rd && reg_addr == hall_pkg::ADDR_AMP_LOW ##1
        ce && reg_rd && reg_addr == hall_pkg::ADDR_AMP_HIGH |=> reg_rdata == $past(amp_q[15:8], 2))
        else $error("amplitude pair incoherent");
    conv_period_a: assert property (ce && conv_cnt_q == '0 && seen_q && !wrote_q |-> gap_q == per_q)
        else $error("conversion spacing wrong");
    thr_flags_a: assert property (ce ##1 1'b1 |-> prox_q == $past(sw_en && above_thr(amp_q, pthr_q))
        && touch_q == $past(sw_en && above_thr(amp_q, tthr_q)))
        else $error("threshold flags wrong");

    lin_path_c: cover property (st_q == hall_pkg::ST_DIVIDE ##[1:40] st_q == hall_pkg::ST_UPDATE);
    touch_c:    cover property ($rose(touch_q));
    south_c:    cover property ($rose(pol_q) ##[1:200] prox_q);

endmodule
`default_nettype wire

/* File: host_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
    // Clock
    input  wire logic       clk,
    // Register port of the device
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One write or one read, taken at the edge after launch
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge clk) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(posedge clk) #1;
        q         = reg_rdata;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // Idle lines must not echo the last transfer
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // Low then high amplitude byte on consecutive edges, so the pair is coherent
    task automatic read_pair(output logic [7:0] lo, output logic [7:0] hi);
        @(posedge clk) #1;
        reg_addr = 8'h17;
        reg_rd   = 1'b1;
        @(posedge clk) #1;
        lo       = reg_rdata;
        reg_addr = 8'h18;
        @(posedge clk) #1;
        hi       = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = 8'hE7;
    endtask

    // Tuning always full, target above base, prox below touch
    task automatic configure(input logic [3:0] div, input logic [7:0] prox, input logic [7:0] cfg);
        logic [7:0] q;
        access(8'h90, {4'h3, div}, 1'b1, q);
        access(8'h91, 8'hA3, 1'b1, q);
        access(8'hA1, prox, 1'b1, q);
        access(8'hA2, prox + 8'h30, 1'b1, q);
        access(8'hA0, cfg, 1'b1, q);
    endtask
endmodule
`default_nettype wire

/* File: test_hall_effect_sensing_ui.sv */
`timescale 1ns/1ps
`default_nettype none
module test_hall_effect_sensing_ui;
    logic        clk        = 1'b0;
    logic        rst_b      = 1'b0;
    logic        ce         = 1'b1;
    logic        meas_valid = 1'b0;
    logic [15:0] ch4_count  = 16'h0000;
    logic [15:0] ch5_count  = 16'h0000;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  q;
    logic        reg_wr;
    logic        reg_rd;
    logic        prox;
    logic        touch;
    logic        pol;
    logic        evt;
    logic        conv;
    logic [3:0]  charge_div;
    logic [3:0]  at_base;
    logic [3:0]  at_target;
    logic [1:0]  at_mode;
    integer      seed       = 89;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          amp        = 0;
    int          pp         = 0;
    int          tp         = 0;
    int          pl         = 0;
    int          ev         = 0;
    int          lin        = 0;
    int          en         = 1;
    int          pthr       = 0;

    always #4 clk = ~clk;

    hall_effect_sensing_ui #(
        .CH_W      (16),
        .LIN_NUMER (32'h0100_0000)
    ) i_hall_effect_sensing_ui (
        .clk                     (clk),
        .rst_b                   (rst_b),
        .ce                      (ce),
        .ch4_count               (ch4_count),
        .ch5_count               (ch5_count),
        .meas_valid              (meas_valid),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rdata               (reg_rdata),
        .conv_start              (conv),
        .charge_div              (charge_div),
        .automatic_tuning_mode   (at_mode),
        .automatic_tuning_base   (at_base),
        .automatic_tuning_target (at_target),
        .magnetic_prox_out       (prox),
        .magnetic_touch_out      (touch),
        .magnetic_polarity       (pol),
        .magnetic_event          (evt)
    );

    host_master_model i_host_master_model (
        .clk       (clk),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    task automatic give_verdict;
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input int e);
        tests_run++;
        if (got !== e[15:0]) begin
            num_errors++;
            $display("unexpected at %0t: got %h, model %h", $time, got, e[15:0]);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input int e);
        logic [7:0] r;
        i_host_master_model.access(a, 8'h00, 1'b0, r);
        check_val({8'h00, r}, e);
    endtask

    task automatic check_state;
        logic [7:0] lo;
        logic [7:0] hi;
        rd_check(8'h16, (tp << 2) | (pp << 1) | pl);
        i_host_master_model.read_pair(lo, hi);
        check_val({8'h00, lo}, amp & 8'hFF);
        check_val({8'h00, hi}, amp >> 8);
        rd_check(8'h11, ev << 2);
        check_val({15'h0000, prox}, pp);
        check_val({15'h0000, touch}, tp);
        check_val({15'h0000, pol}, pl);
        check_val({15'h0000, evt}, ev);
    endtask

    // Pulse spacing measured between two conversion requests
    task automatic check_conv(input int div);
        int n;
        n = 0;
        while (conv !== 1'b1 && n < 5000) begin
            @(posedge clk) #1;
            n++;
        end
        n = 0;
        @(posedge clk) #1;
        while (conv !== 1'b1 && n < 5000) begin
            @(posedge clk) #1;
            n++;
        end
        check_val(16'(n + 1), (div + 1) * hall_pkg::CONV_BASE_CYCLES);
    endtask

    // Flags follow the stored amplitude, so threshold writes move them too
    task automatic model_thr(input int p, input int t);
        int np;
        int nt;
        np = amp > (p << 4);
        nt = amp > (t << 4);
        ev = ((np && !pp) || (nt && !tp)) ? !ev : ev;
        pp = np;
        tp = nt;
    endtask

    task automatic sample(input int c4, input int c5);
        int d;
        @(posedge clk) #1;
        ch4_count  = c4[15:0];
        ch5_count  = c5[15:0];
        meas_valid = 1'b1;
        @(posedge clk) #1;
        meas_valid = 1'b0;
        ch4_count  = ~ch4_count;
        ch5_count  = ~ch5_count;
        // Inverse path needs about 35 cycles
        repeat (40) @(posedge clk);
        if (en == 0) return;
        d   = c4 > c5 ? c4 - c5 : c5 - c4;
        amp = lin == 0 ? d : d == 0 ? 16'hFFFF : 32'h0100_0000 / d;
        amp = amp > 16'hFFFF ? 16'hFFFF : amp;
        model_thr(pthr, pthr + 8'h30);
        pl  = c5 > c4;
        check_state();
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        rd_check(8'h90, 8'h30);
        rd_check(8'h91, 8'h82);
        rd_check(8'hA0, 8'h01);
        rd_check(8'hA1, 8'h10);
        rd_check(8'hA2, 8'h40);
        rd_check(8'h11, 8'h00);
        rd_check(8'h7E, 8'h00);
        i_host_master_model.access(8'h16, 8'hFF, 1'b1, q);
        rd_check(8'h16, 8'h00);
        // Frozen clock enable must drop the write
        ce = 1'b0;
        i_host_master_model.access(8'hA1, 8'h77, 1'b1, q);
        ce = 1'b1;
        rd_check(8'hA1, 8'h10);
        i_host_master_model.configure(4'h5, 8'h10, 8'h01);
        rd_check(8'h90, 8'h35);
        check_val({12'h000, charge_div}, 5);
        check_val({14'h0, at_mode}, 3);
        check_val({8'h00, at_target, at_base}, 8'hA3);
        check_conv(5);
        pthr = 8'h10;
        sample(16'h0400, 16'h0300);
        sample(16'h0300, 16'h0401);
        sample(16'h0300, 16'h0701);
        for (int i = 0; i < 12; i++) begin
            sample($random(seed) & 16'h07FF, $random(seed) & 16'h07FF);
        end
        i_host_master_model.configure(4'h2, 8'h80, 8'h03);
        lin  = 1;
        pthr = 8'h80;
        model_thr(8'h80, 8'h40);
        model_thr(8'h80, 8'hB0);
        check_conv(2);
        sample(16'h0200, 16'h0200);
        sample(16'h0200, 16'h0280);
        for (int i = 0; i < 8; i++) begin
            sample($random(seed) & 16'h3FFF, $random(seed) & 16'h3FFF);
        end
        // Switch off clears the proximity and touch flags and drops samples
        i_host_master_model.access(8'hA0, 8'h00, 1'b1, q);
        en = 0;
        repeat (4) @(posedge clk);
        #1;
        check_val({15'h0000, prox}, 0);
        check_val({15'h0000, touch}, 0);
        sample(16'h1234, 16'h0010);
        rd_check(8'h17, amp & 8'hFF);
        rd_check(8'h18, amp >> 8);
        rd_check(8'h11, ev << 2);
        give_verdict();
    end
endmodule
`default_nettype wire
